//--- rtl/rscl_fb_div.sv
// dual-modulus feedback divider, n = b * p + a
`timescale 1ns/100ps
`default_nettype none
module rscl_fb_div (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hold,
	input  wire logic        tick,
	input  wire logic [1:0]  prescaler_sel,
	input  wire logic [4:0]  a_count,
	input  wire logic [12:0] b_count,
	output var  logic        div_tick
);
	logic [5:0]  pre_cnt;
	logic [4:0]  a_left;
	logic [12:0] b_cnt;
	logic [5:0]  pre_mod;
	logic [5:0]  cur_mod;

	function automatic logic [5:0] rscl_modulus(input logic [1:0] sel);
		case (sel)
			rscl_pkg::PRE_SEL_8:  rscl_modulus = rscl_pkg::PRE_MOD_8;
			rscl_pkg::PRE_SEL_16: rscl_modulus = rscl_pkg::PRE_MOD_16;
			default:              rscl_modulus = rscl_pkg::PRE_MOD_32;
		endcase
	endfunction : rscl_modulus

	// p + 1 while the a counter still runs; expects a not above b
	always_comb begin
		pre_mod = rscl_modulus(prescaler_sel);
		cur_mod = (a_left != 5'h00) ? 6'(pre_mod + 6'h01) : pre_mod;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt  <= 6'h00;
			a_left   <= 5'h00;
			b_cnt    <= 13'h0000;
			div_tick <= 1'b0;
		end else if (hold) begin
			pre_cnt  <= 6'h00;
			a_left   <= a_count;
			b_cnt    <= 13'h0000;
			div_tick <= 1'b0;
		end else begin
			div_tick <= 1'b0;
			if (tick) begin
				if (pre_cnt == 6'(cur_mod - 6'h01)) begin
					pre_cnt <= 6'h00;
					if (b_cnt == 13'(b_count - 13'h0001)) begin
						b_cnt    <= 13'h0000;
						a_left   <= a_count;
						div_tick <= 1'b1;
					end else begin
						b_cnt <= 13'(b_cnt + 13'h0001);
						if (a_left != 5'h00) begin
							a_left <= 5'(a_left - 5'h01);
						end
					end
				end else begin
					pre_cnt <= 6'(pre_cnt + 6'h01);
				end
			end
		end
	end
endmodule : rscl_fb_div
`default_nettype wire

//--- rtl/rscl_latch_bank.sv
// serially written latch bank of the synthesizer transceiver, with apb view
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// RL1: three-wire port shifts words, strobe loads latch
// RL2: select bits zero, zero load control latch
// RL3: select zero, zero, one loads only Tx
// RL4: select one, zero loads LO latch
// RL5: select one, one loads Rx latch
// RL6: four power-down bits, one powers down
// RL7: two-bit Tx output power field
// RL8: three-bit charge pump current setting field
// RL9: two-bit LO output power field
// RL10: LO mute holds LO off until lock
// RL11: Tx mute holds Tx off until lock
// RL12: three-state bit floats charge pump output
// RL13: polarity bit one positive, zero negative
// RL14: three-bit select drives diagnostic output pin
// RL15: counter reset bit holds counters reset
// RL16: host writes spare bits zero, one
// RL17: three-bit receive LO phase, one encoding off
// RL18: three-bit Tx modulation phase select field
// RL19: gain bit one forces maximum pump current
// RL20: feedback divides by b times p plus a
module rscl_latch_bank (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [11:0]                 paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output var  logic [31:0]                 prdata,
	output var  logic                        pready,
	output var  logic                        pslverr,
	input  wire rscl_pkg::rscl_serial_pins_t serial_pins,
	input  wire logic                        pll_lock_pin,
	input  wire logic                        vco_tick,
	input  wire logic                        aux_fb_tick,
	input  wire logic                        ref_tick,
	output var  logic                        rx_filter_powerdown,
	output var  logic                        pll_powerdown,
	output var  logic                        vco_powerdown,
	output var  logic                        tx_powerdown,
	output var  logic [1:0]                  tx_power_sel,
	output var  logic [1:0]                  lo_power_sel,
	output var  logic [2:0]                  cp_current_eff,
	output var  logic                        cp_tristate,
	output var  logic                        pfd_polarity,
	output var  logic                        counter_hold_reset,
	output var  logic                        diag_output_pin,
	output var  logic                        lo_output_enable,
	output var  logic                        tx_output_enable,
	output var  logic [2:0]                  rx_lo_phase_sel,
	output var  logic                        rx_lo_enable,
	output var  logic [2:0]                  mod_phase_sel,
	output var  logic                        fb_div_tick,
	output var  logic                        rx_hp_boost,
	output var  logic [1:0]                  rx_bandwidth_sel,
	output var  logic [2:0]                  rx_gain_sel
);
	typedef enum logic [2:0] {
		RSCL_TGT_NONE = 3'b000,
		RSCL_TGT_CTRL = 3'b001,
		RSCL_TGT_TX   = 3'b010,
		RSCL_TGT_LO   = 3'b011,
		RSCL_TGT_RX   = 3'b100
	} rscl_target_t;

	rscl_pkg::rscl_ctrl_latch_t ctrl_latch;
	rscl_pkg::rscl_tx_latch_t   tx_latch;
	rscl_pkg::rscl_lo_latch_t   lo_latch;
	rscl_pkg::rscl_rx_latch_t   rx_latch;
	rscl_pkg::rscl_ctrl_latch_t shift_as_ctrl;

	logic [3:0]  pins_stable;
	logic        sclk_s;
	logic        sdata_s;
	logic        sle_s;
	logic        lock_s;
	logic        sclk_prev;
	logic        sle_prev;
	logic        sclk_rise;
	logic        strobe;
	logic [23:0] shift_reg;
	logic [4:0]  bit_cnt;
	logic        short_word;
	logic        short_clr;
	logic [7:0]  word_count;
	logic        serial_en;
	logic        fb_tick_sel;
	rscl_target_t target;
	logic        setup_phase;
	logic        access_wr;

	rscl_sync #(
		.W(4)
	) u_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in ({pll_lock_pin, serial_pins.serial_latch_strobe,
		            serial_pins.serial_data, serial_pins.serial_clock}),
		.stable   (pins_stable)
	);

	assign sclk_s  = pins_stable[0];
	assign sdata_s = pins_stable[1];
	assign sle_s   = pins_stable[2];
	assign lock_s  = pins_stable[3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_prev <= 1'b0;
			sle_prev  <= 1'b0;
		end else begin
			sclk_prev <= sclk_s;
			sle_prev  <= sle_s;
		end
	end

	assign sclk_rise = sclk_s && !sclk_prev;
	// strobes are ignored while software has the serial port switched off
	assign strobe    = sle_s && !sle_prev && serial_en;

	// shift msb first on each rising serial clock edge that does not meet a strobe in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_reg <= 24'h000000;
			bit_cnt   <= 5'h00;
		end else if (strobe) begin
			bit_cnt <= 5'h00;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[22:0], sdata_s}; // [RL1]
			if (bit_cnt != rscl_pkg::BIT_CNT_MAX) begin
				bit_cnt <= 5'(bit_cnt + 5'h01);
			end
		end
	end

	function automatic rscl_target_t rscl_decode(input logic [23:0] word);
		if (word[1:0] == rscl_pkg::SEL_CTRL) begin
			rscl_decode = RSCL_TGT_CTRL;
		end else if (word[2:0] == rscl_pkg::SEL_TX) begin
			rscl_decode = RSCL_TGT_TX;
		end else if (word[1:0] == rscl_pkg::SEL_LO) begin
			rscl_decode = RSCL_TGT_LO;
		end else if (word[1:0] == rscl_pkg::SEL_RX) begin
			rscl_decode = RSCL_TGT_RX;
		end else begin
			rscl_decode = RSCL_TGT_NONE;
		end
	endfunction : rscl_decode

	assign target        = rscl_decode(shift_reg);
	assign shift_as_ctrl = rscl_pkg::rscl_ctrl_latch_t'(shift_reg);

	// one latch per strobe; select code one, zero, one reaches none here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_latch <= rscl_pkg::rscl_ctrl_latch_t'(rscl_pkg::CTRL_RESET);
			tx_latch   <= rscl_pkg::rscl_tx_latch_t'(rscl_pkg::TX_RESET);
			lo_latch   <= rscl_pkg::rscl_lo_latch_t'(rscl_pkg::LO_RESET);
			rx_latch   <= rscl_pkg::rscl_rx_latch_t'(rscl_pkg::RX_RESET);
		end else if (strobe) begin
			case (target)
				RSCL_TGT_CTRL: ctrl_latch <= rscl_pkg::rscl_ctrl_latch_t'(shift_reg); // [RL1] [RL2]
				RSCL_TGT_TX:   tx_latch   <= rscl_pkg::rscl_tx_latch_t'(shift_reg);   // [RL3]
				RSCL_TGT_LO:   lo_latch   <= rscl_pkg::rscl_lo_latch_t'(shift_reg);   // [RL4]
				RSCL_TGT_RX:   rx_latch   <= rscl_pkg::rscl_rx_latch_t'(shift_reg);   // [RL5]
				default: begin
				end
			endcase
		end
	end

	// sticky flag for a strobe after fewer than a whole word; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_word <= 1'b0;
			word_count <= 8'h00;
		end else begin
			short_word <= (strobe && (bit_cnt < rscl_pkg::WORD_BITS)) || (short_word && !short_clr);
			if (strobe) begin
				word_count <= 8'(word_count + 8'h01);
			end
		end
	end

	// latch fields straight to the analogue controls
	assign rx_filter_powerdown = ctrl_latch.rx_filter_powerdown; // [RL6]
	assign pll_powerdown       = ctrl_latch.pll_powerdown;       // [RL6]
	assign vco_powerdown       = ctrl_latch.vco_powerdown;       // [RL6]
	assign tx_powerdown        = ctrl_latch.tx_powerdown;        // [RL6]
	assign tx_power_sel        = {ctrl_latch.tx_power_sel_hi, ctrl_latch.tx_power_sel_lo}; // [RL7]
	assign lo_power_sel        = ctrl_latch.lo_level_or_phase_sel; // [RL9]
	assign cp_tristate         = ctrl_latch.cp_tristate;         // [RL12]
	assign pfd_polarity        = ctrl_latch.pfd_polarity;        // [RL13]
	assign counter_hold_reset  = ctrl_latch.counter_hold_reset;  // [RL15]
	assign rx_lo_phase_sel     = tx_latch.rx_lo_phase_sel;       // [RL17]
	assign mod_phase_sel       = tx_latch.mod_phase_sel;         // [RL18]
	assign rx_hp_boost         = rx_latch.hp_boost;
	assign rx_bandwidth_sel    = rx_latch.bandwidth_sel;
	assign rx_gain_sel         = rx_latch.gain_sel;

	// registered output stage: lock gating, pump current and diagnostic mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_output_enable <= 1'b0;
			tx_output_enable <= 1'b0;
			rx_lo_enable     <= 1'b0;
			cp_current_eff   <= 3'h0;
			diag_output_pin  <= 1'b0;
		end else begin
			lo_output_enable <= !ctrl_latch.vco_powerdown &&
			                    !(ctrl_latch.lo_mute_until_lock && !lock_s); // [RL10]
			tx_output_enable <= !ctrl_latch.tx_powerdown &&
			                    !(ctrl_latch.tx_mute_until_lock && !lock_s); // [RL11]
			rx_lo_enable     <= (tx_latch.rx_lo_phase_sel != rscl_pkg::RX_LO_OFF); // [RL17]
			cp_current_eff   <= lo_latch.cp_gain_max ? rscl_pkg::CP_CURRENT_MAX
			                                         : ctrl_latch.cp_current_sel; // [RL8] [RL19]
			case (ctrl_latch.outmux_sel) // [RL14]
				rscl_pkg::MUX_LOCK: diag_output_pin <= lock_s;
				rscl_pkg::MUX_REF:  diag_output_pin <= ref_tick;
				rscl_pkg::MUX_NDIV: diag_output_pin <= fb_div_tick;
				rscl_pkg::MUX_HIGH: diag_output_pin <= 1'b1;
				default:            diag_output_pin <= 1'b0;
			endcase
		end
	end

	assign fb_tick_sel = lo_latch.fb_mux_sel ? aux_fb_tick : vco_tick;

	rscl_fb_div u_fb_div (
		.clk           (pclk),
		.rst_n         (presetn),
		.hold          (ctrl_latch.counter_hold_reset), // [RL15]
		.tick          (fb_tick_sel),
		.prescaler_sel (lo_latch.prescaler_sel),        // [RL20]
		.a_count       (lo_latch.a_count),
		.b_count       (lo_latch.b_count),
		.div_tick      (fb_div_tick)
	);

	// apb slave: zero wait states, read data and error captured in setup
	assign pready      = 1'b1;
	assign setup_phase = psel && !penable;
	assign access_wr   = psel && penable && pwrite;
	assign short_clr   = access_wr && (paddr == rscl_pkg::ADDR_STATUS) && pwdata[rscl_pkg::STAT_SHORT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_en <= rscl_pkg::CFG_SER_EN_RESET;
		end else if (access_wr && (paddr == rscl_pkg::ADDR_CONFIG)) begin
			serial_en <= pwdata[rscl_pkg::CFG_SER_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= 1'b0;
			case (paddr)
				rscl_pkg::ADDR_CTRL:   prdata <= {8'h00, ctrl_latch};
				rscl_pkg::ADDR_TX:     prdata <= {8'h00, tx_latch};
				rscl_pkg::ADDR_LO:     prdata <= {8'h00, lo_latch};
				rscl_pkg::ADDR_RX:     prdata <= {8'h00, rx_latch};
				rscl_pkg::ADDR_STATUS: begin
					prdata                                     <= 32'h00000000;
					prdata[rscl_pkg::STAT_LOCK]                <= lock_s;
					prdata[rscl_pkg::STAT_SHORT]               <= short_word;
					prdata[rscl_pkg::STAT_CNT_LSB +: 8]        <= word_count;
				end
				rscl_pkg::ADDR_CONFIG: prdata <= {31'h00000000, serial_en};
				default: begin
					prdata  <= 32'h00000000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_strobe;
		strobe;
	endsequence

	sequence seq_ctrl_word;
		seq_strobe ##0 (shift_reg[1:0] == rscl_pkg::SEL_CTRL);
	endsequence

	sequence seq_tx_word;
		seq_strobe ##0 (shift_reg[2:0] == rscl_pkg::SEL_TX);
	endsequence

	a_shift_bit_in: assert property (sclk_rise && !strobe |=> shift_reg[0] == $past(sdata_s)) // [RL1]
		else $error("serial data bit not shifted in");

	a_ctrl_latch_load: assert property (seq_ctrl_word |=> ctrl_latch == $past(shift_reg)) // [RL2]
		else $error("control word not loaded");

	a_tx_only_load: assert property (seq_tx_word |=> tx_latch == $past(shift_reg) && $stable(ctrl_latch)
		&& $stable(lo_latch) && $stable(rx_latch)) // [RL3]
		else $error("tx word not loaded alone");

	a_lo_latch_load: assert property (seq_strobe ##0 (shift_reg[1:0] == rscl_pkg::SEL_LO)
		|=> lo_latch == $past(shift_reg) && $stable(tx_latch)) // [RL4]
		else $error("lo word not loaded");

	a_rx_latch_load: assert property (seq_strobe ##0 (shift_reg[1:0] == rscl_pkg::SEL_RX)
		|=> rx_latch == $past(shift_reg) && $stable(ctrl_latch)) // [RL5]
		else $error("rx word not loaded");

	a_powerdown_follow: assert property (seq_ctrl_word |=> tx_powerdown == $past(shift_as_ctrl.tx_powerdown)
		&& rx_filter_powerdown == $past(shift_as_ctrl.rx_filter_powerdown)) // [RL6]
		else $error("power-down bit does not follow control word");

	a_lo_mute_lock: assert property (ctrl_latch.lo_mute_until_lock && !lock_s |=> !lo_output_enable) // [RL10]
		else $error("lo output on before lock");

	a_tx_mute_lock: assert property (ctrl_latch.tx_mute_until_lock && !lock_s ##1 !lock_s
		|-> !tx_output_enable) // [RL11]
		else $error("tx output on before lock");

	a_cp_gain_max: assert property (lo_latch.cp_gain_max |=> cp_current_eff == rscl_pkg::CP_CURRENT_MAX) // [RL19]
		else $error("maximum pump current not forced");

	a_cp_current_prog: assert property (!lo_latch.cp_gain_max
		|=> cp_current_eff == $past(ctrl_latch.cp_current_sel)) // [RL8]
		else $error("programmed pump current not used");

	a_counter_hold: assert property (counter_hold_reset ##1 counter_hold_reset |-> !fb_div_tick) // [RL15]
		else $error("divider ran while counters held");

	a_diag_lock: assert property (ctrl_latch.outmux_sel == rscl_pkg::MUX_LOCK
		|=> diag_output_pin == $past(lock_s)) // [RL14]
		else $error("diagnostic pin does not show lock");
endmodule : rscl_latch_bank
`default_nettype wire

//--- rtl/rscl_pkg.sv
// constants, field layouts and carriers of the serial latch bank
package rscl_pkg;

	localparam int          WORD_W       = 24;
	localparam logic [4:0]  WORD_BITS    = 5'h18;
	localparam logic [4:0]  BIT_CNT_MAX  = 5'h1f;

	// latch select codes in the low bits of a word
	localparam logic [1:0]  SEL_CTRL     = 2'h0;
	localparam logic [2:0]  SEL_TX       = 3'h1;
	localparam logic [1:0]  SEL_LO       = 2'h2;
	localparam logic [1:0]  SEL_RX       = 2'h3;

	// apb byte addresses
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_TX      = 12'h004;
	localparam logic [11:0] ADDR_LO      = 12'h008;
	localparam logic [11:0] ADDR_RX      = 12'h00c;
	localparam logic [11:0] ADDR_STATUS  = 12'h010;
	localparam logic [11:0] ADDR_CONFIG  = 12'h014;

	localparam int          STAT_LOCK    = 0;
	localparam int          STAT_SHORT   = 1;
	localparam int          STAT_CNT_LSB = 8;
	localparam int          CFG_SER_EN   = 0;
	localparam logic        CFG_SER_EN_RESET = 1'b1;

	localparam logic [2:0]  CP_CURRENT_MAX = 3'h7;
	localparam logic [2:0]  RX_LO_OFF      = 3'h7;

	// diagnostic multiplexer selections
	localparam logic [2:0]  MUX_LOW      = 3'h0;
	localparam logic [2:0]  MUX_LOCK     = 3'h1;
	localparam logic [2:0]  MUX_REF      = 3'h2;
	localparam logic [2:0]  MUX_NDIV     = 3'h3;
	localparam logic [2:0]  MUX_HIGH     = 3'h4;

	localparam logic [1:0]  PRE_SEL_8    = 2'h0;
	localparam logic [1:0]  PRE_SEL_16   = 2'h1;
	localparam logic [5:0]  PRE_MOD_8    = 6'h08;
	localparam logic [5:0]  PRE_MOD_16   = 6'h10;
	localparam logic [5:0]  PRE_MOD_32   = 6'h20;

	typedef struct packed {
		logic       serial_clock;
		logic       serial_data;
		logic       serial_latch_strobe;
	} rscl_serial_pins_t;

	typedef struct packed {
		logic       reserved;
		logic       lo_mute_until_lock;
		logic       tx_mute_until_lock;
		logic       cp_tristate;
		logic       pfd_polarity;
		logic       counter_hold_reset;
		logic [2:0] outmux_sel;
		logic [1:0] lo_level_or_phase_sel;
		logic [2:0] cp_current_sel;
		logic       tx_power_sel_hi;
		logic       tx_power_sel_lo;
		logic       rx_filter_powerdown;
		logic       pll_powerdown;
		logic       vco_powerdown;
		logic       tx_powerdown;
		logic       spare_bit_hi;
		logic       spare_bit_lo;
		logic [1:0] latch_select;
	} rscl_ctrl_latch_t;

	typedef struct packed {
		logic [14:0] reserved;
		logic [2:0]  mod_phase_sel;
		logic [2:0]  rx_lo_phase_sel;
		logic [2:0]  latch_select;
	} rscl_tx_latch_t;

	typedef struct packed {
		logic [1:0]  prescaler_sel;
		logic        cp_gain_max;
		logic        fb_mux_sel;
		logic [12:0] b_count;
		logic [4:0]  a_count;
		logic [1:0]  latch_select;
	} rscl_lo_latch_t;

	typedef struct packed {
		logic [15:0] reserved;
		logic        hp_boost;
		logic [1:0]  bandwidth_sel;
		logic [2:0]  gain_sel;
		logic [1:0]  latch_select;
	} rscl_rx_latch_t;

	// all sections powered down, tx power off, positive polarity
	localparam logic [23:0] CTRL_RESET = 24'h0803f4;
	// receive lo output off
	localparam logic [23:0] TX_RESET   = 24'h000038;
	// smallest legal b count
	localparam logic [23:0] LO_RESET   = 24'h000180;
	localparam logic [23:0] RX_RESET   = 24'h000000;

endpackage : rscl_pkg

//--- rtl/rscl_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rscl_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] stable
);
	logic [W-1:0] meta;
	logic [W-1:0] sync2;
	logic [W-1:0] sync3;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta  <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			meta  <= async_in;
			sync2 <= meta;
			sync3 <= sync2;
		end
	end

	// a bit changes only once the second and third stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stable <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (sync2[i] == sync3[i]) begin
					stable[i] <= sync3[i];
				end
			end
		end
	end
endmodule : rscl_sync
`default_nettype wire

//--- sim/rscl_host_model.sv
// host-side model that writes words over the three-wire serial port
`timescale 1ns/100ps
`default_nettype none
module rscl_host_model (
	output var rscl_pkg::rscl_serial_pins_t pins
);
	initial pins = '0;

	// clock idles low outside frames; a released data line shows the inverse of its last bit
	task automatic send(input logic [23:0] w, input int n, input logic slow);
		int q;
		q = 40; // half of the 80 ns link clock period
		for (int i = n - 1; i >= 0; i--) begin
			pins.serial_data = w[i]; // msb first, select bits last
			#(q) pins.serial_clock = 1'b1;
			#(q) pins.serial_clock = 1'b0;
		end
		pins.serial_data = ~w[0];
		#(q) pins.serial_latch_strobe = 1'b1; // strobe moves the word into its latch
		#80 pins.serial_latch_strobe = 1'b0;
		#(slow ? 3 * q : q); // random idle gap between frames
	endtask : send
endmodule : rscl_host_model
`default_nettype wire

//--- sim/tb_rf_synth_control_latch_bank.sv
// self-checking bench of the serial latch bank with a host model and apb reads
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_rf_synth_control_latch_bank;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pll_lock_pin, vco_tick, aux_fb_tick, ref_tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic rx_filter_powerdown, pll_powerdown, vco_powerdown, tx_powerdown, cp_tristate, pfd_polarity;
	logic counter_hold_reset, diag_output_pin, lo_output_enable, tx_output_enable, rx_lo_enable, fb_div_tick;
	logic rx_hp_boost, e, en, sf;
	logic [1:0] tx_power_sel, lo_power_sel, rx_bandwidth_sel;
	logic [2:0] cp_current_eff, rx_lo_phase_sel, mod_phase_sel, rx_gain_sel;
	logic [23:0] e_l [4];
	logic [23:0] sh, w;
	int num_errors, n_checks, cnt, tk;
	rscl_pkg::rscl_serial_pins_t serial_pins;

	rscl_host_model host (.pins(serial_pins));
	rscl_latch_bank dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.serial_pins, .pll_lock_pin, .vco_tick, .aux_fb_tick, .ref_tick, .rx_filter_powerdown, .pll_powerdown,
		.vco_powerdown, .tx_powerdown, .tx_power_sel, .lo_power_sel, .cp_current_eff, .cp_tristate, .pfd_polarity,
		.counter_hold_reset, .diag_output_pin, .lo_output_enable, .tx_output_enable, .rx_lo_phase_sel,
		.rx_lo_enable, .mod_phase_sel, .fb_div_tick, .rx_hp_boost, .rx_bandwidth_sel, .rx_gain_sel);

	initial begin
		pclk = 1'b0;
		#0.7;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		vco_tick <= 1'($urandom);
		aux_fb_tick <= 1'($urandom);
		ref_tick <= 1'($urandom);
	end

	task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// reference decode of a strobed word
	task automatic send(input logic [23:0] wd, input int n);
		sh = 24'((sh << n) | (wd & 24'((1 << n) - 1)));
		host.send(wd, n, 1'($urandom));
		if (en) begin
			cnt++;
			if (n < 24) sf = 1'b1;
			if (sh[1:0] == 2'h0) e_l[0] = sh;
			else if (sh[2:0] == 3'h1) e_l[1] = sh;
			else if (sh[1:0] == 2'h2) e_l[2] = sh;
			else if (sh[1:0] == 2'h3) e_l[3] = sh;
		end
	endtask : send

	task automatic check_all();
		rscl_pkg::rscl_ctrl_latch_t c;
		rscl_pkg::rscl_tx_latch_t t;
		rscl_pkg::rscl_lo_latch_t l;
		rscl_pkg::rscl_rx_latch_t x;
		logic d1;
		c = e_l[0];
		t = e_l[1];
		l = e_l[2];
		x = e_l[3];
		for (int i = 0; i < 4; i++) begin
			apb(12'(4 * i), 1'b0, 32'h0);
			`CHK("latch", {1'b0, 8'h00, e_l[i]}, {e, r})
		end
		apb(rscl_pkg::ADDR_STATUS, 1'b0, 32'h0);
		`CHK("status", {1'b0, 16'h0, 8'(cnt), 6'h0, sf, pll_lock_pin}, {e, r})
		`CHK("pd", {c.rx_filter_powerdown, c.pll_powerdown, c.vco_powerdown, c.tx_powerdown}, {rx_filter_powerdown, pll_powerdown, vco_powerdown, tx_powerdown})
		`CHK("pwr", {c.tx_power_sel_hi, c.tx_power_sel_lo, c.lo_level_or_phase_sel}, {tx_power_sel, lo_power_sel})
		`CHK("cp", l.cp_gain_max ? rscl_pkg::CP_CURRENT_MAX : c.cp_current_sel, cp_current_eff)
		`CHK("flags", {c.cp_tristate, c.pfd_polarity, c.counter_hold_reset}, {cp_tristate, pfd_polarity, counter_hold_reset})
		`CHK("mute", {!c.vco_powerdown && !(c.lo_mute_until_lock && !pll_lock_pin), !c.tx_powerdown && !(c.tx_mute_until_lock && !pll_lock_pin)}, {lo_output_enable, tx_output_enable})
		`CHK("txl", {t.rx_lo_phase_sel, t.rx_lo_phase_sel != rscl_pkg::RX_LO_OFF, t.mod_phase_sel}, {rx_lo_phase_sel, rx_lo_enable, mod_phase_sel})
		`CHK("rxl", {x.hp_boost, x.bandwidth_sel, x.gain_sel}, {rx_hp_boost, rx_bandwidth_sel, rx_gain_sel})
		if (c.outmux_sel != rscl_pkg::MUX_REF && c.outmux_sel != rscl_pkg::MUX_NDIV)
			`CHK("diag", (c.outmux_sel == rscl_pkg::MUX_LOCK) ? pll_lock_pin : (c.outmux_sel == rscl_pkg::MUX_HIGH), diag_output_pin)
		else begin
			// source sampled at one edge shows on the pin right after that edge and is read at the next
			@(posedge pclk) d1 = (c.outmux_sel == rscl_pkg::MUX_REF) ? ref_tick : fb_div_tick;
			@(posedge pclk) `CHK("diag_src", d1, diag_output_pin)
		end
	endtask : check_all

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	initial begin
		#300000;
		num_errors++;
		give_verdict();
	end

	initial begin
		void'($urandom(71873));
		{psel, penable, pwrite, paddr, pwdata, pll_lock_pin, vco_tick, aux_fb_tick, ref_tick} = '0;
		presetn = 1'b0;
		e_l = '{rscl_pkg::CTRL_RESET, rscl_pkg::TX_RESET, rscl_pkg::LO_RESET, rscl_pkg::RX_RESET};
		{sh, cnt, sf, en, num_errors, n_checks} = '0;
		en = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		check_all();
		apb(rscl_pkg::ADDR_CONFIG, 1'b0, 32'h0);
		`CHK("cfg", {1'b0, 32'h1}, {e, r})
		apb(12'h018, 1'b0, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {e, r})
		apb(rscl_pkg::ADDR_CTRL, 1'b1, 32'h00ffffff);
		apb(rscl_pkg::ADDR_CTRL, 1'b0, 32'h0);
		`CHK("ro", {1'b0, 8'h00, rscl_pkg::CTRL_RESET}, {e, r})
		for (int k = 0; k < 40; k++) begin
			w = 24'($urandom);
			case (k % 5)
				0: w = {w[23:18], 3'(k / 5), w[14:4], 4'h4}; // spare bits zero, one
				1: w[2:0] = 3'h1;
				2: {w[19], w[1:0]} = 3'h6;
				3: w[1:0] = 2'h3;
				default: w[2:0] = 3'h5;
			endcase
			@(posedge pclk) pll_lock_pin <= 1'($urandom);
			send(w, 24);
			check_all();
		end
		send(24'($urandom) | 24'h000003, 20); // short word aimed at the rx latch
		check_all();
		apb(rscl_pkg::ADDR_STATUS, 1'b1, 32'h2);
		sf = 1'b0;
		apb(rscl_pkg::ADDR_CONFIG, 1'b1, 32'h0);
		en = 1'b0;
		send(24'($urandom) & 24'hfffffc, 24);
		check_all();
		apb(rscl_pkg::ADDR_CONFIG, 1'b1, 32'h1);
		en = 1'b1;
		send(24'h000004, 24);
		check_all();
		// hold the counters while a small divide ratio is loaded, then release
		send(24'h040004, 24);
		send(24'h40018a, 24);
		send(24'h000004, 24);
		check_all();
		do @(posedge pclk); while (fb_div_tick !== 1'b1);
		tk = 0;
		do begin
			tk += vco_tick;
			@(posedge pclk);
		end while (fb_div_tick !== 1'b1);
		`CHK("fbdiv", 3 * int'(rscl_pkg::PRE_MOD_16) + 2, tk)
		give_verdict();
	end
endmodule : tb_rf_synth_control_latch_bank
`default_nettype wire
